// ==== hdl/gep_defs.vh ====
// Constants for the sixteen-pin general-purpose port.
`ifndef GEP_DEFS_VH
`define GEP_DEFS_VH
`define GEP_ADDR_W 32
`define GEP_DATA_W 32
`define GEP_PINS 16
`define GEP_OFF_ENABLE 32'h01B00000
`define GEP_OFF_DIRECTION 32'h01B00004
`define GEP_OFF_VALUE 32'h01B00008
`define GEP_OFF_EVMODE 32'h01B00020
`define GEP_RST_ENABLE 16'h0000
`define GEP_RST_DIRECTION 16'h0000
`define GEP_RST_VALUE 16'h0000
`define GEP_RST_EVMODE 2'h0
`define GEP_MODE_OFF 2'h0
`define GEP_MODE_RISE 2'h1
`define GEP_MODE_FALL 2'h2
`define GEP_MODE_BOTH 2'h3
`define GEP_UPPER_ZERO 16'h0000
`endif

// ==== hdl/gep_port.v ====
// Sixteen-pin general-purpose port with enable, direction and value registers.
//
// Functional notes
// R1 - Sixteen pins, each with enable and direction
// R2 - Each pin individually input or output
// R3 - Output pin drives written value bit
// R4 - Input pin value read returns sampled level
// R5 - Pin activity raises interrupt and DMA events
// R6 - Pin works only while enable bit set
// R7 - Direction zero input, one output
// R8 - Direction ignored while pin disabled
// R9 - All direction bits zero after reset
// R10 - Reserved upper bits read zero, writes ignored
`include "gep_defs.vh"

module gep_port #(
   parameter PINS = `GEP_PINS
) (
   // Clock and reset.
   input wire i_core_clk,
   input wire i_rst,
   // Register port.
   input wire i_reg_sel,
   input wire i_reg_wr,
   input wire [`GEP_ADDR_W-1:0] i_reg_addr,
   input wire [`GEP_DATA_W-1:0] i_reg_wdata,
   output reg [`GEP_DATA_W-1:0] o_reg_rdata,
   output reg o_reg_ack,
   // Pins, split into input, output and output enable.
   input wire [PINS-1:0] i_general_pins,
   output reg [PINS-1:0] o_general_pins,
   output reg [PINS-1:0] o_general_pins_oe,
   // Event outputs, one-cycle pulses.
   output reg o_cpu_irq,
   output reg o_dma_event
);

   ////////////////////////////////////////////////////////////////////////
   // Register storage.
   reg [PINS-1:0] pin_enable_r;
   reg [PINS-1:0] pin_direction_r;
   reg [PINS-1:0] pin_value_r;
   reg [1:0] ev_mode_r;
   reg [`GEP_DATA_W-1:0] rdata_nxt;
   reg event_hit;

   // Access decode.
   wire wr_en;
   wire rd_en;
   wire hit_enable;
   wire hit_direction;
   wire hit_value;
   wire hit_evmode;
   wire wr_enable;
   wire wr_direction;
   wire wr_value;
   wire wr_evmode;

   // Per-pin views.
   wire [PINS-1:0] in_pins;
   wire [PINS-1:0] out_pins;
   wire [PINS-1:0] pin_level;
   wire [PINS-1:0] rise;
   wire [PINS-1:0] fall;
   wire [PINS-1:0] value_view;
   wire [PINS-1:0] drive_nxt;
   wire any_rise;
   wire any_fall;

   ////////////////////////////////////////////////////////////////////////
   // Every access compares the full address, so aliases stay unmapped.
   assign wr_en = i_reg_sel & i_reg_wr;
   assign rd_en = i_reg_sel & ~i_reg_wr;
   assign hit_enable = (i_reg_addr == `GEP_OFF_ENABLE);
   assign hit_direction = (i_reg_addr == `GEP_OFF_DIRECTION);
   assign hit_value = (i_reg_addr == `GEP_OFF_VALUE);
   assign hit_evmode = (i_reg_addr == `GEP_OFF_EVMODE);
   assign wr_enable = wr_en & hit_enable;
   assign wr_direction = wr_en & hit_direction;
   assign wr_value = wr_en & hit_value;
   assign wr_evmode = wr_en & hit_evmode;

   // A direction bit only counts while the same pin is enabled.
   assign in_pins = pin_enable_r & ~pin_direction_r; // R8
   assign out_pins = pin_enable_r & pin_direction_r; // R7
   assign any_rise = |rise;
   assign any_fall = |fall;

   ////////////////////////////////////////////////////////////////////////
   // Per pin: two-flop synchroniser, edge memory, read view, drive value.
   // Edges are only looked for on enabled inputs, so a pin that turns
   // from output to input can raise one event as its level settles.
   genvar g;
   generate
      for (g = 0; g < PINS; g = g + 1) begin : g_pin
         reg sync1_r;
         reg sync2_r;
         reg prev_r;
         always @(posedge i_core_clk) begin
            if (i_rst) begin
               sync1_r <= 1'b0;
               sync2_r <= 1'b0;
               prev_r <= 1'b0;
            end else begin
               sync1_r <= i_general_pins[g];
               sync2_r <= sync1_r;
               prev_r <= sync2_r;
            end
         end
         assign pin_level[g] = sync2_r;
         assign rise[g] = sync2_r & ~prev_r & in_pins[g];
         assign fall[g] = ~sync2_r & prev_r & in_pins[g];
         assign value_view[g] = in_pins[g] ? sync2_r : pin_value_r[g]; // R4
         assign drive_nxt[g] = pin_value_r[g] & out_pins[g]; // R3
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Event selection; one pulse per cycle however many pins moved.
   always @* begin
      case (ev_mode_r)
         `GEP_MODE_RISE: begin
            event_hit = any_rise; // R5
         end
         `GEP_MODE_FALL: begin
            event_hit = any_fall; // R5
         end
         `GEP_MODE_BOTH: begin
            event_hit = any_rise | any_fall; // R5
         end
         default: begin
            event_hit = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Read multiplexer; reserved upper bits always read zero.
   always @* begin
      rdata_nxt = {`GEP_DATA_W{1'b0}};
      if (hit_enable) begin
         rdata_nxt = {`GEP_UPPER_ZERO, pin_enable_r}; // R10
      end else if (hit_direction) begin
         rdata_nxt = {`GEP_UPPER_ZERO, pin_direction_r}; // R10
      end else if (hit_value) begin
         rdata_nxt = {`GEP_UPPER_ZERO, value_view}; // R4
      end else if (hit_evmode) begin
         rdata_nxt = {{(`GEP_DATA_W-2){1'b0}}, ev_mode_r};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus answer: every access is acknowledged, even an unmapped one.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_reg_ack <= 1'b0;
      end else begin
         o_reg_ack <= i_reg_sel;
      end
   end

   // Read data stands zero outside a read answer.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_reg_rdata <= {`GEP_DATA_W{1'b0}};
      end else if (rd_en) begin
         o_reg_rdata <= rdata_nxt;
      end else begin
         o_reg_rdata <= {`GEP_DATA_W{1'b0}};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes; upper data bits are simply not stored.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         pin_enable_r <= `GEP_RST_ENABLE;
      end else if (wr_enable) begin
         pin_enable_r <= i_reg_wdata[PINS-1:0]; // R1
      end
   end

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         pin_direction_r <= `GEP_RST_DIRECTION; // R9
      end else if (wr_direction) begin
         pin_direction_r <= i_reg_wdata[PINS-1:0]; // R2
      end
   end

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         pin_value_r <= `GEP_RST_VALUE;
      end else if (wr_value) begin
         pin_value_r <= i_reg_wdata[PINS-1:0];
      end
   end

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         ev_mode_r <= `GEP_RST_EVMODE;
      end else if (wr_evmode) begin
         ev_mode_r <= i_reg_wdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Disabled pins are released so board pulls or other users own them.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_general_pins <= {PINS{1'b0}};
         o_general_pins_oe <= {PINS{1'b0}};
      end else begin
         o_general_pins <= drive_nxt; // R3
         o_general_pins_oe <= out_pins; // R6
      end
   end

   // Both event outputs carry the same pulse; the consumer picks one.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_cpu_irq <= 1'b0;
         o_dma_event <= 1'b0;
      end else begin
         o_cpu_irq <= event_hit; // R5
         o_dma_event <= event_hit; // R5
      end
   end

endmodule // gep_port

// ==== verification/gep_port_asserts.sv ====
// Checker for the general-purpose port.
module gep_port_chk (
   input wire i_core_clk, i_rst, i_reg_sel, i_reg_wr,
   input wire [31:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
   input wire o_reg_ack, o_cpu_irq, o_dma_event,
   input wire [15:0] o_general_pins, o_general_pins_oe
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   sequence en_wr;
      i_reg_sel && i_reg_wr && i_reg_addr == 32'h01B00000;
   endsequence
   AST_ACK: assert property (i_reg_sel |=> o_reg_ack)
      else $error("ack");
   AST_NOACK: assert property (!i_reg_sel |=> !o_reg_ack)
      else $error("stray ack");
   AST_IDLE: assert property (!o_reg_ack |-> o_reg_rdata == 0)
      else $error("idle rdata");
   AST_DRIVE: assert property ((o_general_pins & ~o_general_pins_oe) == 0)
      else $error("drive");
   AST_EVT: assert property (o_cpu_irq == o_dma_event)
      else $error("event");
   AST_RST: assert property ($past(i_rst) |-> o_general_pins_oe == 0)
      else $error("reset oe");
   AST_UPPER: assert property (i_reg_sel && !i_reg_wr |=> o_reg_rdata[31:16] == 0)
      else $error("upper");
   // A second enable write would move the target, so it is excluded.
   AST_EN: assert property (en_wr ##1 !en_wr |=>
      (o_general_pins_oe & ~$past(i_reg_wdata[15:0], 2)) == 0) else $error("en");
endmodule // gep_port_chk

// ==== verification/gep_pin_model.sv ====
// Model of the devices wired to the general pins.
module gep_pin_model (
   input wire logic [15:0] i_drv, i_oe, i_ext,
   output logic [15:0] o_pin
);
   // Driven pins win the wire; elsewhere the outside device drives.
   assign o_pin = (i_oe & i_drv) | (~i_oe & i_ext);
endmodule // gep_pin_model

// ==== verification/testbench.sv ====
// Self-checking testbench for the general-purpose port.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, sel = 0, wr = 0, ack, irq, dma;
   logic [31:0] adr = 0, wd = 0, rd_v, rdat;
   logic [15:0] ext = 16'h0000, pin, out, oe;
   int bad_count = 0, total_checks = 0;
   always #25 clk = ~clk;
   gep_port u_dut (.i_core_clk(clk), .i_rst(rst), .i_reg_sel(sel),
      .i_reg_wr(wr), .i_reg_addr(adr), .i_reg_wdata(wd), .o_reg_rdata(rdat),
      .o_reg_ack(ack), .i_general_pins(pin), .o_general_pins(out),
      .o_general_pins_oe(oe), .o_cpu_irq(irq), .o_dma_event(dma));
   gep_pin_model u_pins (.i_drv(out), .i_oe(oe), .i_ext(ext), .o_pin(pin));
   task chk(string n, logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   task acc(logic w, logic [31:0] a, d);
      @(posedge clk); #1 sel = 1; wr = w; adr = a; wd = d;
      @(posedge clk); #1 sel = 0; rd_v = rdat;
      chk("ack", {31'h0, ack}, 1);
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task t_reset;
      acc(0, 32'h01B00004, 0); chk("dir", rd_v, 0);
      acc(0, 32'h01B0000C, 0); chk("unmapped", rd_v, 0);
      $display("reset test done");
   endtask
   task t_out;
      acc(1, 32'h01B00000, 32'h000000FF);
      acc(1, 32'h01B00004, 32'hFFFFFFFF);
      acc(1, 32'h01B00008, 32'h0000A5C3);
      @(posedge clk); #1;
      chk("oe", oe, 16'h00FF);
      chk("out", out, 16'h00C3);
      acc(0, 32'h01B00004, 0); chk("dir", rd_v, 32'h0000FFFF);
      $display("output test done");
   endtask
   task t_in;
      acc(1, 32'h01B00000, 32'h0000FFFF);
      acc(1, 32'h01B00004, 0);
      repeat (6) @(posedge clk);
      acc(1, 32'h01B00020, 32'h3);
      repeat (4) @(posedge clk);
      #1 chk("quiet", {31'h0, irq}, 0);
      ext = 16'h3C5A;
      for (int n = 0; n < 8 && irq !== 1; n++) begin
         @(posedge clk); #1;
      end
      chk("irq", {31'h0, irq}, 1);
      chk("dma", {31'h0, dma}, 1);
      if (irq !== 1) close_out;
      @(posedge clk); #1;
      chk("pulse", {31'h0, irq}, 0);
      acc(0, 32'h01B00008, 0); chk("in", rd_v, 32'h3C5A);
      $display("input test done");
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1 rst = 0;
      t_reset;
      t_out;
      t_in;
      close_out;
   end
endmodule // testbench
bind gep_port gep_port_chk u_chk (.*);
